// File: rtl/rtcs_consts.vh
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH
// register addresses
`define A_HALT      4'h1
`define A_OSC_FAULT_IRQ_ENABLE      4'h2
`define A_RATE      4'h4
`define A_CENT      4'h6
`define A_CLK_LAST  4'h7
`define A_CAL       4'h8
`define A_DOG       4'h9
`define A_AL_MON    4'ha
`define A_AL_DATE   4'hb
`define A_AL_HOUR   4'hc
`define A_AL_MIN    4'hd
`define A_AL_SEC    4'he
`define A_FLAGS     4'hf
// bit positions
`define B_TOP       7
`define B_SUB       6
`define B_FIXED_32K_PIN      5
`define B_OF        2
// reset values
`define RST_RATE    4'h1
`define RST_DOG     8'h00
`define RST_OUT     1'b1
`define RST_FIXED_32K_PIN    1'b1
`define RST_OF      1'b1
// repeat codes {alarm_repeat_sel}
`define RPT_MIN     5'h1e
`define RPT_HOUR    5'h1c
`define RPT_DAY     5'h18
`define RPT_MONTH   5'h10
`define RPT_YEAR    5'h00
// wave rate codes
`define RATE_OFF    4'h0
`define RATE_32K    4'h1
// watchdog resolution codes
`define RES_16HZ    3'h0
`define RES_4HZ     3'h1
`define RES_1HZ     3'h2
`define RES_4S      3'h3
`define RES_1MIN    3'h4
// divider taps
`define DIV_W       15
`define DIV16_MASK  11'h7ff
`define TAP_512     5
// timing
`define CLK_NS      8
`define OSC_LOSS_NS 100000
`define OSC_LOSS_CYC ((`OSC_LOSS_NS + `CLK_NS - 1) / `CLK_NS)
`define REC_NS      200000000
`define REC_CYC     ((`REC_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: rtl/rtcs_dog.v
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_consts.vh"
module rtcs_dog (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_tick16,
    input  wire       i_load,
    input  wire       i_restart,
    input  wire [4:0] i_mult,
    input  wire [2:0] i_res,
    output reg        o_expire
);
    reg  [14:0] cnt_q;
    reg         run_q;
    reg  [14:0] period;
    wire        valid = (i_res <= `RES_1MIN);

    // period counted in 16 Hz ticks
    always @* begin
        case (i_res)
            `RES_16HZ: period = {10'h000, i_mult};
            `RES_4HZ:  period = {8'h00, i_mult, 2'h0};
            `RES_1HZ:  period = {6'h00, i_mult, 4'h0};
            `RES_4S:   period = {4'h0, i_mult, 6'h00};
            `RES_1MIN: period = {i_mult, 10'h000} - {4'h0, i_mult, 6'h00};
            default:   period = 15'h0000;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q    <= 15'h0000;
            run_q    <= 1'b0;
            o_expire <= 1'b0;
        end else begin
            o_expire <= 1'b0;
            if (i_load) begin
                if (!valid || (i_mult == 5'h00 && i_res == `RES_16HZ)) begin
                    run_q <= 1'b0;
                end else if (i_mult == 5'h00) begin
                    run_q    <= 1'b0;
                    o_expire <= 1'b1;
                end else begin
                    run_q <= 1'b1;
                    cnt_q <= period;
                end
            end else if (i_restart && run_q) begin
                cnt_q <= period;
            end else if (run_q && i_tick16) begin
                if (cnt_q == 15'h0001) begin
                    o_expire <= 1'b1;
                    run_q    <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 15'h0001;
                end
            end
        end
    end
endmodule // rtcs_dog
`default_nettype wire

// File: rtl/rtcs_top.v
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_consts.vh"
module rtcs_top #(
    parameter        DOG_USES_PIN = 0,
    parameter        WAVE_DEF_ON  = 1,
    parameter [31:0] OSC_LOSS_CYC = `OSC_LOSS_CYC,
    parameter [31:0] REC_CYC      = `REC_CYC
) (
    input  wire       I_CLOCK,
    input  wire       I_RST,
    input  wire       I_OSC_CLK,
    input  wire       I_REG_WR,
    input  wire       I_REG_RD,
    input  wire [3:0] I_REG_ADDR,
    input  wire [7:0] I_REG_WDATA,
    output reg  [7:0] O_REG_RDATA,
    input  wire [3:0] I_PTR_ADDR,
    input  wire       I_SEC_TICK,
    input  wire [6:0] I_SEC,
    input  wire [6:0] I_MIN,
    input  wire [5:0] I_HOUR,
    input  wire [5:0] I_DATE,
    input  wire [4:0] I_MONTH,
    input  wire [7:0] I_YEAR,
    input  wire       I_CENTURY_ROLL,
    output reg  [1:0] O_CENTURY_COUNT,
    output reg        O_LEAP_ALLOWED,
    output reg        O_WAVE_PIN,
    output reg        O_FIXED_32K_PIN,
    output reg        O_OSC_HALT,
    output wire       O_IRQ_PIN_O,
    output reg        O_IRQ_PIN_OE,
    output wire       O_DOG_RESET_PULSE_N_O,
    output reg        O_DOG_RESET_PULSE_N_OE
);
    reg  [3:0]  wave_rate_sel_q;
    reg         wave_enable_q;
    reg         fixed_32k_enable_q;
    reg         osc_fault_irq_enable_q;
    reg         out_level_q;
    reg         freq_test_bit_q;
    reg  [5:0]  cal_q;
    reg  [7:0]  dog_q;
    reg         alarm_irq_enable_q;
    reg  [4:0]  al_mon_q;
    reg  [7:0]  al_date_q;
    reg  [7:0]  al_hour_q;
    reg  [7:0]  al_min_q;
    reg  [7:0]  al_sec_q;
    reg         dog_expired_flag_q;
    reg         alarm_hit_flag_q;
    reg         osc_fault_flag_q;
    reg         alarm_irq_q;
    reg         dog_irq_q;
    reg         alarm_pend_q;
    reg         osc_s1_q;
    reg         osc_s2_q;
    reg         osc_s3_q;
    reg  [`DIV_W-1:0] div_q;
    reg  [31:0] loss_q;
    reg         osc_dead_q;
    reg  [31:0] rec_q;
    reg         match;
    reg  [7:0]  rd_d;

    wire       wr_flags  = I_REG_WR && I_REG_ADDR == `A_FLAGS;
    wire       rd_flags  = I_REG_RD && I_REG_ADDR == `A_FLAGS;
    wire       wr_dog    = I_REG_WR && I_REG_ADDR == `A_DOG;
    wire       wr_clock  = I_REG_WR && I_REG_ADDR <= `A_CLK_LAST;
    wire       osc_rise  = osc_s2_q && !osc_s3_q;
    wire       osc_run   = !O_OSC_HALT && !osc_dead_q;
    wire       tick16    = osc_rise && osc_run && div_q[10:0] == `DIV16_MASK;
    wire [3:0] tap       = wave_rate_sel_q - `RATE_32K;
    wire [4:0] rpt       = {al_date_q[`B_SUB], al_date_q[`B_TOP], al_hour_q[`B_TOP],
                            al_min_q[`B_TOP], al_sec_q[`B_TOP]};
    wire       dog_expire;
    // the timer loads on the write edge, before dog_q holds the new byte
    wire [7:0] dog_new   = wr_dog ? I_REG_WDATA : dog_q;
    wire       irq_cfg   = osc_fault_irq_enable_q || alarm_irq_enable_q || dog_q != `RST_DOG;
    wire       irq_act   = alarm_irq_q || dog_irq_q ||
                           (osc_fault_irq_enable_q && osc_fault_flag_q);
    wire       year_div4 = I_YEAR[4] ? (I_YEAR[3:0] == 4'h2 || I_YEAR[3:0] == 4'h6) :
                           (I_YEAR[3:0] == 4'h0 || I_YEAR[3:0] == 4'h4 ||
                            I_YEAR[3:0] == 4'h8);

    assign O_IRQ_PIN_O           = 1'b0;
    assign O_DOG_RESET_PULSE_N_O = 1'b0;

    rtcs_dog u_dog (
        .i_clk     (I_CLOCK),
        .i_rst     (I_RST),
        .i_tick16  (tick16),
        .i_load    (wr_dog),
        .i_restart (wr_clock),
        .i_mult    (dog_new[6:2]),
        .i_res     ({dog_new[`B_TOP], dog_new[1:0]}),
        .o_expire  (dog_expire)
    );

    // alarm comparison by repeat code
    always @* begin
        case (rpt)
            `RPT_MIN:   match = I_SEC == al_sec_q[6:0];
            `RPT_HOUR:  match = I_SEC == al_sec_q[6:0] && I_MIN == al_min_q[6:0];
            `RPT_DAY:   match = I_SEC == al_sec_q[6:0] && I_MIN == al_min_q[6:0] &&
                                I_HOUR == al_hour_q[5:0];
            `RPT_MONTH: match = I_SEC == al_sec_q[6:0] && I_MIN == al_min_q[6:0] &&
                                I_HOUR == al_hour_q[5:0] && I_DATE == al_date_q[5:0];
            `RPT_YEAR:  match = I_SEC == al_sec_q[6:0] && I_MIN == al_min_q[6:0] &&
                                I_HOUR == al_hour_q[5:0] && I_DATE == al_date_q[5:0] &&
                                I_MONTH == al_mon_q;
            default:    match = 1'b1;
        endcase
    end

    // oscillator sampling, divider, stop detection
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            osc_s1_q   <= 1'b0;
            osc_s2_q   <= 1'b0;
            osc_s3_q   <= 1'b0;
            div_q      <= {`DIV_W{1'b0}};
            loss_q     <= 32'h0000_0000;
            osc_dead_q <= 1'b0;
        end else begin
            osc_s1_q <= I_OSC_CLK;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            if (osc_rise) begin
                loss_q     <= 32'h0000_0000;
                osc_dead_q <= 1'b0;
            end else if (loss_q >= OSC_LOSS_CYC) begin
                osc_dead_q <= 1'b1;
            end else begin
                loss_q <= loss_q + 32'h0000_0001;
            end
            if (osc_rise && !O_OSC_HALT)
                div_q <= div_q + {{(`DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // register writes and control bits
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_OSC_HALT             <= 1'b0;
            osc_fault_irq_enable_q <= 1'b0;
            wave_rate_sel_q        <= `RST_RATE;
            wave_enable_q          <= (WAVE_DEF_ON != 0);
            fixed_32k_enable_q     <= `RST_FIXED_32K_PIN;
            out_level_q            <= `RST_OUT;
            freq_test_bit_q        <= 1'b0;
            cal_q                  <= 6'h00;
            dog_q                  <= `RST_DOG;
            alarm_irq_enable_q     <= 1'b0;
            al_mon_q               <= 5'h00;
            al_date_q              <= 8'h00;
            al_hour_q              <= 8'h00;
            al_min_q               <= 8'h00;
            al_sec_q               <= 8'h00;
            O_CENTURY_COUNT        <= 2'h0;
        end else begin
            if (I_REG_WR) begin
                case (I_REG_ADDR)
                    `A_HALT:    O_OSC_HALT <= I_REG_WDATA[`B_TOP];
                    `A_OSC_FAULT_IRQ_ENABLE:    osc_fault_irq_enable_q <= I_REG_WDATA[`B_TOP];
                    `A_RATE:    wave_rate_sel_q <= I_REG_WDATA[7:4];
                    `A_CAL: begin
                        out_level_q     <= I_REG_WDATA[`B_TOP];
                        freq_test_bit_q <= I_REG_WDATA[`B_SUB];
                        cal_q           <= I_REG_WDATA[5:0];
                    end
                    `A_DOG:     dog_q <= I_REG_WDATA;
                    `A_AL_MON: begin
                        alarm_irq_enable_q <= I_REG_WDATA[`B_TOP];
                        wave_enable_q      <= I_REG_WDATA[`B_SUB];
                        fixed_32k_enable_q <= I_REG_WDATA[`B_FIXED_32K_PIN];
                        al_mon_q           <= I_REG_WDATA[4:0];
                    end
                    `A_AL_DATE: al_date_q <= I_REG_WDATA;
                    `A_AL_HOUR: al_hour_q <= I_REG_WDATA;
                    `A_AL_MIN:  al_min_q <= I_REG_WDATA;
                    `A_AL_SEC:  al_sec_q <= I_REG_WDATA;
                    default: begin
                    end
                endcase
            end
            if (I_CENTURY_ROLL)
                O_CENTURY_COUNT <= O_CENTURY_COUNT + 2'h1;
            else if (I_REG_WR && I_REG_ADDR == `A_CENT)
                O_CENTURY_COUNT <= I_REG_WDATA[7:6];
        end
    end

    // flags and interrupt sources; a set beats a clear in the same cycle
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            dog_expired_flag_q <= 1'b0;
            alarm_hit_flag_q   <= 1'b0;
            osc_fault_flag_q   <= `RST_OF;
            alarm_irq_q        <= 1'b0;
            dog_irq_q          <= 1'b0;
            alarm_pend_q       <= 1'b0;
        end else begin
            if (I_SEC_TICK && match && I_PTR_ADDR == `A_FLAGS)
                alarm_pend_q <= 1'b1;
            else if (I_PTR_ADDR != `A_FLAGS)
                alarm_pend_q <= 1'b0;
            if ((I_SEC_TICK && match) || alarm_pend_q) begin
                if (I_PTR_ADDR != `A_FLAGS) begin
                    alarm_hit_flag_q <= 1'b1;
                    if (alarm_irq_enable_q)
                        alarm_irq_q <= 1'b1;
                end
            end else if (rd_flags) begin
                alarm_hit_flag_q <= 1'b0;
                alarm_irq_q      <= 1'b0;
            end
            if (dog_expire)
                dog_expired_flag_q <= 1'b1;
            else if (rd_flags)
                dog_expired_flag_q <= 1'b0;
            if (dog_expire && DOG_USES_PIN == 0)
                dog_irq_q <= 1'b1;
            else if (wr_dog)
                dog_irq_q <= 1'b0;
            if (O_OSC_HALT || osc_dead_q)
                osc_fault_flag_q <= 1'b1;
            else if (wr_flags && !I_REG_WDATA[`B_OF])
                osc_fault_flag_q <= 1'b0;
        end
    end

    // read data, sampled on the read strobe
    always @* begin
        case (I_REG_ADDR)
            `A_HALT:    rd_d = {O_OSC_HALT, 7'h00};
            `A_OSC_FAULT_IRQ_ENABLE:    rd_d = {osc_fault_irq_enable_q, 7'h00};
            `A_RATE:    rd_d = {wave_rate_sel_q, 4'h0};
            `A_CENT:    rd_d = {O_CENTURY_COUNT, 6'h00};
            `A_CAL:     rd_d = {out_level_q, freq_test_bit_q, cal_q};
            `A_DOG:     rd_d = dog_q;
            `A_AL_MON:  rd_d = {alarm_irq_enable_q, wave_enable_q, fixed_32k_enable_q,
                                al_mon_q};
            `A_AL_DATE: rd_d = al_date_q;
            `A_AL_HOUR: rd_d = al_hour_q;
            `A_AL_MIN:  rd_d = al_min_q;
            `A_AL_SEC:  rd_d = al_sec_q;
            `A_FLAGS:   rd_d = {dog_expired_flag_q, alarm_hit_flag_q, 3'h0,
                                osc_fault_flag_q, 2'h0};
            default:    rd_d = 8'h00;
        endcase
    end

    always @(posedge I_CLOCK) begin
        if (I_RST)
            O_REG_RDATA <= 8'h00;
        else if (I_REG_RD)
            O_REG_RDATA <= rd_d;
    end

    // pins
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_WAVE_PIN             <= 1'b0;
            O_FIXED_32K_PIN        <= 1'b0;
            O_IRQ_PIN_OE           <= 1'b0;
            O_DOG_RESET_PULSE_N_OE <= 1'b0;
            O_LEAP_ALLOWED         <= 1'b0;
            rec_q                  <= 32'h0000_0000;
        end else begin
            if (!wave_enable_q || !osc_run || wave_rate_sel_q == `RATE_OFF)
                O_WAVE_PIN <= 1'b0;
            else if (wave_rate_sel_q == `RATE_32K)
                O_WAVE_PIN <= osc_s2_q;
            else
                O_WAVE_PIN <= div_q[tap];
            O_FIXED_32K_PIN <= fixed_32k_enable_q && osc_run && osc_s2_q;
            if (irq_cfg)
                O_IRQ_PIN_OE <= irq_act;
            else if (freq_test_bit_q && out_level_q)
                O_IRQ_PIN_OE <= !div_q[`TAP_512];
            else
                O_IRQ_PIN_OE <= !out_level_q;
            if (dog_expire && DOG_USES_PIN != 0) begin
                rec_q                  <= REC_CYC;
                O_DOG_RESET_PULSE_N_OE <= 1'b1;
            end else if (rec_q > 32'h0000_0001) begin
                rec_q <= rec_q - 32'h0000_0001;
            end else begin
                rec_q                  <= 32'h0000_0000;
                O_DOG_RESET_PULSE_N_OE <= 1'b0;
            end
            O_LEAP_ALLOWED <= O_CENTURY_COUNT == 2'h0 && year_div4;
        end
    end
endmodule // rtcs_top
`default_nettype wire

// File: tb/rtcs_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_top_asserts #(
    parameter DOG_USES_PIN = 0
) (
    input wire       I_CLOCK,
    input wire       I_RST,
    input wire       I_REG_WR,
    input wire       I_REG_RD,
    input wire [3:0] I_REG_ADDR,
    input wire [7:0] I_REG_WDATA,
    input wire [7:0] O_REG_RDATA,
    input wire       I_CENTURY_ROLL,
    input wire [1:0] O_CENTURY_COUNT,
    input wire       O_LEAP_ALLOWED,
    input wire       O_FIXED_32K_PIN,
    input wire       O_OSC_HALT,
    input wire       O_IRQ_PIN_O,
    input wire       O_IRQ_PIN_OE,
    input wire       O_DOG_RESET_PULSE_N_O,
    input wire       O_DOG_RESET_PULSE_N_OE
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    wire [2:0] wr_res = {I_REG_WDATA[7], I_REG_WDATA[1:0]};
    sequence s_dog_zero_wr;
        I_REG_WR && I_REG_ADDR == 4'h9 && I_REG_WDATA[6:2] == 5'h00
            && wr_res != 3'h0 && wr_res < 3'h5;
    endsequence
    sequence s_flag_rd;
        I_REG_RD && I_REG_ADDR == 4'hf;
    endsequence
    wire dog_out = DOG_USES_PIN ? O_DOG_RESET_PULSE_N_OE : O_IRQ_PIN_OE;
    a_rdata_hold: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
        else $error("read data moved without a read");
    a_flag_pad_zero: assert property (s_flag_rd |=> (O_REG_RDATA & 8'h3b) == 8'h00)
        else $error("unused flag bits read nonzero");
    a_halt_write: assert property (I_REG_WR && I_REG_ADDR == 4'h1
        |=> O_OSC_HALT == $past(I_REG_WDATA[7]))
        else $error("halt bit not taken from write");
    a_halt_stops_32k: assert property (O_OSC_HALT [*4] |-> !O_FIXED_32K_PIN)
        else $error("fixed 32k output runs while halted");
    a_dog_zero_mult: assert property (s_dog_zero_wr |-> ##[1:4] dog_out)
        else $error("zero multiplier did not expire at once");
    a_dog_pin_idle: assert property (DOG_USES_PIN == 0 |-> !O_DOG_RESET_PULSE_N_OE)
        else $error("reset pulse pin driven on interrupt variant");
    a_open_drain_low: assert property (!O_IRQ_PIN_O && !O_DOG_RESET_PULSE_N_O)
        else $error("open drain pin drives high");
    a_century_step: assert property (I_CENTURY_ROLL
        |=> O_CENTURY_COUNT == $past(O_CENTURY_COUNT) + 2'h1)
        else $error("century count did not step");
    a_century_hold: assert property (!I_CENTURY_ROLL && !(I_REG_WR && I_REG_ADDR == 4'h6)
        |=> $stable(O_CENTURY_COUNT))
        else $error("century count moved by itself");
    a_leap_only_c0: assert property (O_CENTURY_COUNT != 2'h0
        && $past(O_CENTURY_COUNT) != 2'h0 |-> !O_LEAP_ALLOWED)
        else $error("leap day outside century zero");
endmodule // rtcs_top_asserts
`default_nettype wire

// File: tb/rtcs_host.sv
`timescale 1ns/10ps
`default_nettype none
module rtcs_host (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_osc,
    output logic            o_wr,
    output logic            o_rd,
    output logic [3:0]      o_addr,
    output logic [7:0]      o_wdata
);
    // crystal runs free at 8 clock periods, toggling 1 ns after a system clock rising edge
    initial begin
        o_osc = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 4'h0;
        o_wdata = 8'h00;
        #13;
        forever #32 o_osc = ~o_osc;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clk);
        #1 d = i_rdata;
    endtask
endmodule // rtcs_host
`default_nettype wire

// File: tb/rtcs_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
bind rtcs_top rtcs_top_asserts #(.DOG_USES_PIN(DOG_USES_PIN)) chk_u (.I_CLOCK, .I_RST,
    .I_REG_WR, .I_REG_RD, .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA, .I_CENTURY_ROLL,
    .O_CENTURY_COUNT, .O_LEAP_ALLOWED, .O_FIXED_32K_PIN, .O_OSC_HALT, .O_IRQ_PIN_O,
    .O_IRQ_PIN_OE, .O_DOG_RESET_PULSE_N_O, .O_DOG_RESET_PULSE_N_OE);
module rtcs_top_bench;
    logic       clk, rst, osc, wr, rd, tick, roll, wave, fixed_32k_pin, halt;
    logic       irq_o, irq_oe, dog_o, dog_oe, leap;
    logic [3:0] addr, ptr;
    logic [7:0] wdata, rdata, year;
    logic [6:0] sec, tm_min;
    logic [5:0] tm_hour, tm_date;
    logic [4:0] tm_mon;
    logic [1:0] cent;
    int         n_fail, cmp_count, cyc;
    rtcs_host h_u (.i_clk(clk), .i_rdata(rdata), .o_osc(osc), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));
    rtcs_top #(.DOG_USES_PIN(0), .WAVE_DEF_ON(1), .OSC_LOSS_CYC(200), .REC_CYC(20)) dut_u (
        .I_CLOCK(clk), .I_RST(rst), .I_OSC_CLK(osc), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_PTR_ADDR(ptr),
        .I_SEC_TICK(tick), .I_SEC(sec), .I_MIN(tm_min), .I_HOUR(tm_hour), .I_DATE(tm_date),
        .I_MONTH(tm_mon), .I_YEAR(year), .I_CENTURY_ROLL(roll), .O_CENTURY_COUNT(cent),
        .O_LEAP_ALLOWED(leap), .O_WAVE_PIN(wave), .O_FIXED_32K_PIN(fixed_32k_pin),
        .O_OSC_HALT(halt), .O_IRQ_PIN_O(irq_o), .O_IRQ_PIN_OE(irq_oe),
        .O_DOG_RESET_PULSE_N_O(dog_o), .O_DOG_RESET_PULSE_N_OE(dog_oe));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        h_u.rd(a, v);
        chk("read data", v, e);
    endtask
    task automatic wait_irq(input logic e, input int n, output int c);
        c = 0;
        while (irq_oe !== e && c < n) begin
            @(posedge clk);
            #1 c++;
        end
        chk("irq pin enable", {7'h00, irq_oe}, {7'h00, e});
    endtask
    task automatic chk_rate(input logic sel, input int e);
        int c;
        logic p;
        c = 0;
        repeat (20) @(posedge clk);
        #1 p = sel ? fixed_32k_pin : wave;
        repeat (1600) begin
            @(posedge clk);
            #1 if ((sel ? fixed_32k_pin : wave) === 1'b1 && p === 1'b0) c++;
            p = sel ? fixed_32k_pin : wave;
        end
        chk("edges", (c >= e - 1 && c <= e + 1) ? e[7:0] : c[7:0], e[7:0]);
    endtask
    task automatic t_reset();
        chk_rd(4'h9, 8'h00);
        chk_rd(4'hf, 8'h04);
        chk_rd(4'ha, 8'h60);
        chk_rd(4'h8, 8'h80);
        chk_rd(4'h1, 8'h00);
        chk("irq pin enable", {7'h00, irq_oe}, 8'h00);
    endtask
    task automatic t_level();
        int c;
        h_u.wr(4'h8, 8'h00);
        wait_irq(1'b1, 5, c);
        h_u.wr(4'h8, 8'h80);
        wait_irq(1'b0, 5, c);
    endtask
    task automatic t_osc();
        int c;
        h_u.wr(4'h2, 8'h80);
        wait_irq(1'b1, 5, c);
        chk_rd(4'hf, 8'h04);
        wait_irq(1'b1, 0, c);
        h_u.wr(4'hf, 8'h00);
        wait_irq(1'b0, 5, c);
        chk_rd(4'hf, 8'h00);
        chk_rate(1'b1, 200);
        h_u.wr(4'h1, 8'h80);
        wait_irq(1'b1, 10, c);
        chk_rate(1'b1, 0);
        h_u.wr(4'h1, 8'h00);
        h_u.wr(4'h2, 8'h00);
        wait_irq(1'b0, 5, c);
    endtask
    task automatic t_wave();
        for (int r = 0; r < 4; r++) begin
            h_u.wr(4'h4, 8'(r << 4));
            chk_rate(1'b0, r == 0 ? 0 : r == 1 ? 200 : 200 >> r);
        end
        h_u.wr(4'ha, 8'h20);
        chk_rate(1'b0, 0);
        h_u.wr(4'ha, 8'h60);
    endtask
    task automatic pulse_sec(input logic [6:0] s);
        @(posedge clk);
        sec <= s;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // alarm fields 01 date, 02 h, 03 min, 30 s with repeat code k
    task automatic al_try(input logic [4:0] k, input logic e);
        int c;
        h_u.wr(4'hb, {k[3], k[4], 6'h01});
        h_u.wr(4'hc, {k[2], 7'h02});
        h_u.wr(4'hd, {k[1], 7'h03});
        h_u.wr(4'he, {k[0], 7'h30});
        pulse_sec(7'h30);
        wait_irq(e, 5, c);
        if (e)
            chk_rd(4'hf, 8'h44);
    endtask
    task automatic t_alarm();
        int c;
        h_u.wr(4'hb, 8'hc0);
        h_u.wr(4'hc, 8'h80);
        h_u.wr(4'hd, 8'h80);
        h_u.wr(4'he, 8'h30);
        h_u.wr(4'ha, 8'he0);
        pulse_sec(7'h31);
        wait_irq(1'b0, 0, c);
        ptr <= 4'hf;
        pulse_sec(7'h30);
        wait_irq(1'b0, 0, c);
        ptr <= 4'h0;
        wait_irq(1'b1, 5, c);
        chk_rd(4'hf, 8'h44);
        wait_irq(1'b0, 0, c);
        chk_rd(4'hf, 8'h04);
        h_u.wr(4'ha, 8'he1);
        tm_min <= 7'h03;
        tm_hour <= 6'h02;
        tm_mon <= 5'h02;
        al_try(5'h1c, 1'b1);
        al_try(5'h18, 1'b1);
        al_try(5'h10, 1'b1);
        al_try(5'h00, 1'b0);
        al_try(5'h05, 1'b1);
        tm_hour <= 6'h05;
        al_try(5'h18, 1'b0);
        al_try(5'h1c, 1'b1);
        for (int a = 11; a < 15; a++)
            h_u.wr(4'(a), 8'h00);
        tm_mon <= 5'h01;
        tm_hour <= 6'h00;
        tm_min <= 7'h00;
        pulse_sec(7'h00);
        wait_irq(1'b0, 0, c);
    endtask
    task automatic t_century();
        chk("leap", {7'h00, leap}, 8'h01);
        for (int i = 1; i < 5; i++) begin
            @(posedge clk);
            roll <= 1'b1;
            @(posedge clk);
            roll <= 1'b0;
            repeat (3) @(posedge clk);
            chk("century", {6'h00, cent}, 8'(i % 4));
            chk("leap", {7'h00, leap}, {7'h00, i % 4 == 0});
        end
    endtask
    task automatic t_dog();
        int c;
        h_u.wr(4'h9, 8'h81);
        repeat (30) @(posedge clk);
        wait_irq(1'b0, 0, c);
        h_u.wr(4'h9, 8'h01);
        wait_irq(1'b1, 10, c);
        chk_rd(4'hf, 8'h84);
        chk_rd(4'hf, 8'h04);
        h_u.wr(4'h9, 8'h00);
        wait_irq(1'b0, 5, c);
        h_u.wr(4'h9, 8'h08);
        repeat (14000) @(posedge clk);
        h_u.wr(4'h2, 8'h00);
        repeat (14000) @(posedge clk);
        h_u.wr(4'h7, 8'h00);
        repeat (14000) @(posedge clk);
        wait_irq(1'b0, 0, c);
        wait_irq(1'b1, 19000, c);
        chk("dog time", {7'h00, c >= 2000}, 8'h01);
        h_u.wr(4'h9, 8'h00);
        wait_irq(1'b0, 5, c);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1;
        tick = 1'b0;
        roll = 1'b0;
        ptr = 4'h0;
        sec = 7'h00;
        tm_min = 7'h00;
        tm_hour = 6'h00;
        tm_date = 6'h01;
        tm_mon = 5'h01;
        year = 8'h04;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_level();
        t_osc();
        t_wave();
        t_alarm();
        t_century();
        t_dog();
        report_and_stop();
    end
endmodule // rtcs_top_bench
`default_nettype wire
